// file: inc/cmdm_params.svh
// Contract
// - Compressed: narrow parameter 16 bits, 32-bit 32
// - Uncompressed: every mapped parameter takes 32 bits
// - Byte counts sum active channel slot sizes
// - Input byte count read-only, 0..127, default 8
// - Output byte count read-only, 0..127, default 8
// - Pointers beyond channel count are ignored
// - Unmapped channel between mapped ones is invalid
// - Zero pointer inside channel count is invalid
// - Holding registers: IN at 256, OUT at 0
// - Holding 000-1FF cyclic, 210-FFFF non-cyclic
// - Coils 000-FFF map to cyclic OUT data
// - Discrete and input registers map cyclic IN
// - Compression picks one or two words per parameter
// - Uncompressed writes: address 0 channel 0, 2 channel 1
// - Non-cyclic words setting: 1 two, 0 one
// - One-word mode cannot fully reach 32-bit parameters
// - Mapping changes apply only at initialisation
// - Invalid count or mapping reported in mapping status
// - One-word mode address is 528 plus parameter minus 1
`ifndef CMDM_PARAMS_SVH
`define CMDM_PARAMS_SVH
`define CMDM_NCH 10
`define CMDM_BYTES_RESET 8'h08
`define CMDM_BYTES_MAX 8'h7f
`define CMDM_AWPP_RESET 8'h01
`define CMDM_AWPP_MAX 8'h01
`define CMDM_WORDS_NONE 2'h0
`define CMDM_WORDS_NARROW 2'h1
`define CMDM_WORDS_WIDE 2'h2
`define CMDM_HR_IN_BASE 16'h0100
`define CMDM_HR_CYC_LAST 16'h01ff
`define CMDM_HR_ACYC_BASE 16'h0210
`define CMDM_BIT_LAST 16'h0fff
`define CMDM_COIL_ON 16'hff00
`define CMDM_FC_RD_COILS 8'h01
`define CMDM_FC_RD_DISC 8'h02
`define CMDM_FC_RD_HOLD 8'h03
`define CMDM_FC_RD_INREG 8'h04
`define CMDM_FC_WR_COIL 8'h05
`define CMDM_FC_WR_REG 8'h06
`define CMDM_FC_WR_COILS 8'h0f
`define CMDM_FC_WR_REGS 8'h10
`define CMDM_FC_RW_REGS 8'h17
`define CMDM_EXC_NONE 8'h00
`define CMDM_EXC_FUNC 8'h01
`define CMDM_EXC_ADDR 8'h02
`define CMDM_STAT_OK 8'h00
`define CMDM_STAT_IN_COUNT 8'h01
`define CMDM_STAT_OUT_COUNT 8'h02
`define CMDM_STAT_IN_MAP 8'h03
`define CMDM_STAT_OUT_MAP 8'h04
`endif

// file: inc/cmdm_pkg.sv
`default_nettype none
package cmdm_pkg;
	typedef enum logic [1:0] {CMDM_W1, CMDM_W8, CMDM_W16, CMDM_W32} cmdm_width_e;
	typedef enum logic [1:0] {CMDM_ST_IDLE, CMDM_ST_INIT, CMDM_ST_RUN} cmdm_state_e;
	typedef struct packed {
		logic [7:0] fc;
		logic [15:0] addr;
		logic [15:0] wdata;
	} cmdm_req_s;
	typedef struct packed {
		logic [15:0] data;
		logic [7:0] exc;
	} cmdm_rsp_s;
	typedef struct packed {
		logic [15:0] param;
		logic hi_word;
		logic write;
		logic partial;
		logic [15:0] wdata;
	} cmdm_acyc_s;
endpackage
`default_nettype wire

// file: rtl/cmdm_slot.sv
`include "cmdm_params.svh"
`default_nettype none
module cmdm_slot (
	input wire logic i_compress,
	input wire cmdm_pkg::cmdm_width_e i_width,
	input wire logic i_active,
	output logic [1:0] o_words
);
	wire logic narrow = i_compress && (i_width != cmdm_pkg::CMDM_W32);
	assign o_words = !i_active ? `CMDM_WORDS_NONE :
		narrow ? `CMDM_WORDS_NARROW : `CMDM_WORDS_WIDE;
endmodule // cmdm_slot
`default_nettype wire

// file: rtl/cmdm_mapper.sv
`include "cmdm_params.svh"
`default_nettype none
module cmdm_mapper #(
	parameter int NCH = `CMDM_NCH
) (
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic i_init,
	input wire logic i_cyclic_compression_enable,
	input wire logic [3:0] i_in_channel_count,
	input wire logic [3:0] i_out_channel_count,
	input wire logic [15:0] i_in_map_pointer [NCH],
	input wire logic [15:0] i_out_map_pointer [NCH],
	input wire cmdm_pkg::cmdm_width_e i_in_width [NCH],
	input wire cmdm_pkg::cmdm_width_e i_out_width [NCH],
	input wire logic [31:0] i_in_value [NCH],
	input wire logic i_awpp_wr,
	input wire logic [7:0] i_awpp_wdata,
	input wire logic i_req_valid,
	input wire cmdm_pkg::cmdm_req_s i_req,
	output logic o_req_ready,
	output logic o_rsp_valid,
	output cmdm_pkg::cmdm_rsp_s o_rsp,
	output logic o_out_wr,
	output logic [3:0] o_out_chan,
	output logic [31:0] o_out_value,
	output logic o_acyc_valid,
	output cmdm_pkg::cmdm_acyc_s o_acyc,
	input wire logic [15:0] i_acyc_rdata,
	output logic [7:0] o_input_cyclic_byte_count,
	output logic [7:0] o_output_cyclic_byte_count,
	output logic [7:0] o_acyclic_words_per_parameter,
	output logic [7:0] o_mapping_status,
	output logic o_running
);
	if (NCH < 1 || NCH > 15) begin : g_chk
		$error("NCH must lie between 1 and 15");
	end

	cmdm_pkg::cmdm_state_e state_reg;
	logic comp_reg;
	logic [3:0] in_cnt_reg;
	logic [3:0] out_cnt_reg;
	logic [15:0] in_ptr_reg [NCH];
	logic [15:0] out_ptr_reg [NCH];
	cmdm_pkg::cmdm_width_e in_w_reg [NCH];
	cmdm_pkg::cmdm_width_e out_w_reg [NCH];
	logic [31:0] out_val_reg [NCH];
	logic [7:0] in_bytes_reg;
	logic [7:0] out_bytes_reg;
	logic [7:0] status_reg;
	logic [7:0] awpp_reg;
	logic rsp_valid_reg;
	cmdm_pkg::cmdm_rsp_s rsp_reg;
	logic out_wr_reg;
	logic [3:0] out_chan_reg;
	logic [31:0] out_value_reg;
	logic acyc_valid_reg;
	cmdm_pkg::cmdm_acyc_s acyc_reg;

	// Slot sizes per channel
	logic [1:0] in_words [NCH];
	logic [1:0] out_words [NCH];
	for (genvar c = 0; c < NCH; c++) begin : g_slot
		cmdm_slot u_in_slot (
			.i_compress(comp_reg),
			.i_width(in_w_reg[c]),
			.i_active(4'(c) < in_cnt_reg),
			.o_words(in_words[c])
		);
		cmdm_slot u_out_slot (
			.i_compress(comp_reg),
			.i_width(out_w_reg[c]),
			.i_active(4'(c) < out_cnt_reg),
			.o_words(out_words[c])
		);
	end

	// Slot start words and totals
	logic [5:0] in_start [NCH];
	logic [5:0] out_start [NCH];
	logic [5:0] in_total;
	logic [5:0] out_total;
	logic in_zero;
	logic out_zero;
	always_comb begin
		in_total = 6'h0;
		out_total = 6'h0;
		in_zero = 1'b0;
		out_zero = 1'b0;
		for (int c = 0; c < NCH; c++) begin
			in_start[c] = in_total;
			out_start[c] = out_total;
			in_total = in_total + {4'h0, in_words[c]};
			out_total = out_total + {4'h0, out_words[c]};
			if (4'(c) < in_cnt_reg && in_ptr_reg[c] == 16'h0000) begin
				in_zero = 1'b1;
			end
			if (4'(c) < out_cnt_reg && out_ptr_reg[c] == 16'h0000) begin
				out_zero = 1'b1;
			end
		end
	end

	wire logic in_cnt_bad = in_cnt_reg > 4'(NCH);
	wire logic out_cnt_bad = out_cnt_reg > 4'(NCH);
	wire logic [7:0] status_next = in_cnt_bad ? `CMDM_STAT_IN_COUNT :
		out_cnt_bad ? `CMDM_STAT_OUT_COUNT :
		in_zero ? `CMDM_STAT_IN_MAP :
		out_zero ? `CMDM_STAT_OUT_MAP : `CMDM_STAT_OK;
	wire logic [7:0] in_bytes_next = {1'b0, in_total, 1'b0};
	wire logic [7:0] out_bytes_next = {1'b0, out_total, 1'b0};

	// Request decode
	wire logic [7:0] fc = i_req.fc;
	wire logic [15:0] addr = i_req.addr;
	wire logic is_hr = fc == `CMDM_FC_RD_HOLD || fc == `CMDM_FC_WR_REG ||
		fc == `CMDM_FC_WR_REGS || fc == `CMDM_FC_RW_REGS;
	wire logic is_coil = fc == `CMDM_FC_RD_COILS || fc == `CMDM_FC_WR_COIL ||
		fc == `CMDM_FC_WR_COILS;
	wire logic is_di = fc == `CMDM_FC_RD_DISC;
	wire logic is_ir = fc == `CMDM_FC_RD_INREG;
	wire logic is_wr = fc == `CMDM_FC_WR_REG || fc == `CMDM_FC_WR_REGS ||
		fc == `CMDM_FC_WR_COIL || fc == `CMDM_FC_WR_COILS;
	wire logic hr_cyc = addr <= `CMDM_HR_CYC_LAST;
	wire logic hr_in = hr_cyc && addr >= `CMDM_HR_IN_BASE;
	wire logic hr_acyc = addr >= `CMDM_HR_ACYC_BASE;
	wire logic bit_ok = addr <= `CMDM_BIT_LAST;
	wire logic use_in = (is_hr && hr_in) || is_di || is_ir;
	wire logic [15:0] hr_word = hr_in ? addr - `CMDM_HR_IN_BASE : addr;
	wire logic [11:0] word_ix = is_hr ? hr_word[11:0] :
		is_ir ? addr[11:0] : {4'h0, addr[11:4]};

	// Word to channel lookup
	logic hit;
	logic [3:0] hit_ch;
	logic hit_k;
	logic hit_two;
	logic [11:0] st;
	logic [1:0] nw;
	always_comb begin
		hit = 1'b0;
		hit_ch = 4'h0;
		hit_k = 1'b0;
		hit_two = 1'b0;
		st = 12'h0;
		nw = 2'h0;
		for (int c = 0; c < NCH; c++) begin
			st = {6'h0, use_in ? in_start[c] : out_start[c]};
			nw = use_in ? in_words[c] : out_words[c];
			if (nw != `CMDM_WORDS_NONE && word_ix >= st && word_ix < st + {10'h0, nw}) begin
				hit = 1'b1;
				hit_ch = 4'(c);
				hit_k = word_ix != st;
				hit_two = nw == `CMDM_WORDS_WIDE;
			end
		end
	end

	wire logic [31:0] sel_val = use_in ? i_in_value[hit_ch] : out_val_reg[hit_ch];
	wire logic [15:0] rd_word = (hit_two && !hit_k) ? sel_val[31:16] : sel_val[15:0];
	wire logic rd_bit = rd_word[addr[3:0]];
	wire logic coil_on = i_req.wdata == `CMDM_COIL_ON;
	logic [15:0] coil_word;
	always_comb begin
		coil_word = rd_word;
		coil_word[addr[3:0]] = coil_on;
	end
	wire logic [15:0] wr_word = is_coil ? coil_word : i_req.wdata;
	wire logic [31:0] wr_val = !hit_two ? {16'h0000, wr_word} :
		hit_k ? {sel_val[31:16], wr_word} : {wr_word, sel_val[15:0]};

	wire logic fc_ok = is_hr || is_coil || is_di || is_ir;
	wire logic range_ok = is_hr ? hr_cyc : bit_ok;
	wire logic cyc_ok = fc_ok && !(is_hr && hr_acyc) && range_ok && hit && !(use_in && is_wr);
	wire logic acyc_go = is_hr && hr_acyc;
	wire logic [7:0] exc_next = !fc_ok ? `CMDM_EXC_FUNC :
		(cyc_ok || acyc_go) ? `CMDM_EXC_NONE : `CMDM_EXC_ADDR;
	wire logic [15:0] rd_data = (is_coil || is_di) ? {15'h0000, rd_bit} : rd_word;

	// Non-cyclic parameter address
	wire logic [15:0] acyc_off = addr - `CMDM_HR_ACYC_BASE;
	wire logic two_word = awpp_reg == `CMDM_AWPP_RESET;
	wire logic [15:0] acyc_param = two_word ? {1'b0, acyc_off[15:1]} + 16'h0001 :
		acyc_off + 16'h0001;

	wire logic take = i_req_valid && o_req_ready;

	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			state_reg <= cmdm_pkg::CMDM_ST_IDLE;
		end else if (i_init) begin
			state_reg <= cmdm_pkg::CMDM_ST_INIT;
		end else if (state_reg == cmdm_pkg::CMDM_ST_INIT) begin
			state_reg <= (status_next == `CMDM_STAT_OK) ? cmdm_pkg::CMDM_ST_RUN :
				cmdm_pkg::CMDM_ST_IDLE;
		end
	end

	// Mapping configuration taken only when initialising
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			comp_reg <= 1'b0;
			in_cnt_reg <= 4'h0;
			out_cnt_reg <= 4'h0;
			for (int c = 0; c < NCH; c++) begin
				in_ptr_reg[c] <= 16'h0000;
				out_ptr_reg[c] <= 16'h0000;
				in_w_reg[c] <= cmdm_pkg::CMDM_W32;
				out_w_reg[c] <= cmdm_pkg::CMDM_W32;
			end
		end else if (i_init) begin
			comp_reg <= i_cyclic_compression_enable;
			in_cnt_reg <= i_in_channel_count;
			out_cnt_reg <= i_out_channel_count;
			in_ptr_reg <= i_in_map_pointer;
			out_ptr_reg <= i_out_map_pointer;
			in_w_reg <= i_in_width;
			out_w_reg <= i_out_width;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			in_bytes_reg <= `CMDM_BYTES_RESET;
			out_bytes_reg <= `CMDM_BYTES_RESET;
			status_reg <= `CMDM_STAT_OK;
		end else if (state_reg == cmdm_pkg::CMDM_ST_INIT) begin
			in_bytes_reg <= in_bytes_next;
			out_bytes_reg <= out_bytes_next;
			status_reg <= status_next;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			awpp_reg <= `CMDM_AWPP_RESET;
		end else if (i_awpp_wr && i_awpp_wdata <= `CMDM_AWPP_MAX) begin
			awpp_reg <= i_awpp_wdata;
		end
	end

	wire logic out_write = take && cyc_ok && is_wr && !use_in;

	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			for (int c = 0; c < NCH; c++) begin
				out_val_reg[c] <= 32'h0000_0000;
			end
		end else if (out_write) begin
			out_val_reg[hit_ch] <= wr_val;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			out_wr_reg <= 1'b0;
			out_chan_reg <= 4'h0;
			out_value_reg <= 32'h0000_0000;
		end else begin
			out_wr_reg <= out_write;
			if (out_write) begin
				out_chan_reg <= hit_ch;
				out_value_reg <= wr_val;
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			acyc_valid_reg <= 1'b0;
			acyc_reg <= '0;
		end else begin
			acyc_valid_reg <= take && acyc_go;
			if (take && acyc_go) begin
				acyc_reg.param <= acyc_param;
				acyc_reg.hi_word <= two_word && !acyc_off[0];
				acyc_reg.write <= is_wr;
				acyc_reg.partial <= !two_word;
				acyc_reg.wdata <= i_req.wdata;
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			rsp_valid_reg <= 1'b0;
			rsp_reg <= '0;
		end else if (acyc_valid_reg) begin
			rsp_valid_reg <= 1'b1;
			rsp_reg.data <= acyc_reg.write ? 16'h0000 : i_acyc_rdata;
			rsp_reg.exc <= `CMDM_EXC_NONE;
		end else begin
			rsp_valid_reg <= take && !acyc_go;
			if (take && !acyc_go) begin
				rsp_reg.data <= (cyc_ok && !is_wr) ? rd_data : 16'h0000;
				rsp_reg.exc <= exc_next;
			end
		end
	end

	assign o_req_ready = state_reg == cmdm_pkg::CMDM_ST_RUN && !acyc_valid_reg && !i_init;
	assign o_rsp_valid = rsp_valid_reg;
	assign o_rsp = rsp_reg;
	assign o_out_wr = out_wr_reg;
	assign o_out_chan = out_chan_reg;
	assign o_out_value = out_value_reg;
	assign o_acyc_valid = acyc_valid_reg;
	assign o_acyc = acyc_reg;
	assign o_input_cyclic_byte_count = in_bytes_reg;
	assign o_output_cyclic_byte_count = out_bytes_reg;
	assign o_acyclic_words_per_parameter = awpp_reg;
	assign o_mapping_status = status_reg;
	assign o_running = state_reg == cmdm_pkg::CMDM_ST_RUN;

	chk_in_bytes_range: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		o_input_cyclic_byte_count <= `CMDM_BYTES_MAX)
		else $error("input byte count out of range");

	chk_out_bytes_range: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		o_output_cyclic_byte_count <= `CMDM_BYTES_MAX)
		else $error("output byte count out of range");

	chk_bytes_sum: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		state_reg == cmdm_pkg::CMDM_ST_INIT |=>
			o_input_cyclic_byte_count == {1'b0, $past(in_total), 1'b0} &&
			o_output_cyclic_byte_count == {1'b0, $past(out_total), 1'b0})
		else $error("byte count differs from slot sum");

	chk_slot_compress: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		comp_reg && in_cnt_reg != 4'h0 && in_w_reg[0] != cmdm_pkg::CMDM_W32 |->
			in_words[0] == `CMDM_WORDS_NARROW)
		else $error("compressed narrow slot not one word");

	chk_slot_plain: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		!comp_reg && out_cnt_reg != 4'h0 |-> out_words[0] == `CMDM_WORDS_WIDE)
		else $error("uncompressed slot not two words");

	chk_unused_ignored: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		in_cnt_reg == 4'h0 |-> in_total == 6'h0)
		else $error("inactive channel counted");

	chk_zero_pointer: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		state_reg == cmdm_pkg::CMDM_ST_INIT && !in_cnt_bad && !out_cnt_bad &&
			(in_zero || out_zero) && !i_init |=>
			o_mapping_status != `CMDM_STAT_OK && !o_running)
		else $error("zero pointer not reported");

	chk_cfg_frozen: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		o_running && !$past(i_init) |-> $stable(comp_reg) && $stable(in_cnt_reg))
		else $error("mapping changed while running");

	chk_write_channel: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		take && !comp_reg && is_hr && is_wr && addr == 16'h0002 && out_cnt_reg >= 4'h2 |=>
			o_out_wr && o_out_chan == 4'h1)
		else $error("word 2 did not reach channel 1");

	chk_one_reg_addr: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		take && acyc_go && awpp_reg == 8'h00 |=>
			o_acyc_valid && o_acyc.param == $past(addr) - 16'h020f && o_acyc.partial)
		else $error("one-register address wrong");

	chk_acyc_answer: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		take && acyc_go |=> !o_rsp_valid ##1 o_rsp_valid && o_rsp.exc == `CMDM_EXC_NONE)
		else $error("non-cyclic answer late");
endmodule // cmdm_mapper
`default_nettype wire

// file: tb/cmdm_master_model.sv
`default_nettype none
module cmdm_master_model (
	input wire logic i_core_clk,
	output logic o_req_valid,
	output cmdm_pkg::cmdm_req_s o_req,
	input wire logic i_req_ready,
	input wire logic i_rsp_valid,
	input wire cmdm_pkg::cmdm_rsp_s i_rsp,
	input wire logic i_acyc_valid,
	input wire cmdm_pkg::cmdm_acyc_s i_acyc,
	output logic [15:0] o_acyc_rdata,
	input wire logic i_out_wr,
	input wire logic [3:0] i_out_chan,
	input wire logic [31:0] i_out_value
);
	timeunit 1ns;
	timeprecision 1ps;
	cmdm_pkg::cmdm_acyc_s last_acyc;
	logic [3:0] last_chan;
	logic [31:0] last_value;
	int wr_cnt = 0;
	initial begin
		o_req_valid = 1'b0;
		o_req = '0;
	end
	// Parameter store answer, derived from the parameter asked for
	assign o_acyc_rdata = i_acyc.param ^ 16'ha5a5;
	always @(negedge i_core_clk) begin
		if (i_out_wr === 1'b1) begin
			last_chan = i_out_chan;
			last_value = i_out_value;
			wr_cnt++;
		end
		if (i_acyc_valid === 1'b1) begin
			last_acyc = i_acyc;
		end
	end
	// One register or coil per request; reads mostly by 03, writes by 16, 06, 05 and 15
	task automatic do_req(input logic [7:0] fc, input logic [15:0] addr, input logic [15:0] wd,
		output cmdm_pkg::cmdm_rsp_s rsp);
		int n;
		logic late;
		n = 0;
		late = 1'b0;
		@(posedge i_core_clk);
		o_req_valid <= 1'b1;
		o_req <= {fc, addr, wd};
		@(negedge i_core_clk);
		while (i_req_ready !== 1'b1 && n < 50) begin
			@(negedge i_core_clk);
			n++;
		end
		late = i_req_ready !== 1'b1;
		@(posedge i_core_clk);
		o_req_valid <= 1'b0;
		n = 0;
		@(negedge i_core_clk);
		while (i_rsp_valid !== 1'b1 && n < 10) begin
			@(negedge i_core_clk);
			n++;
		end
		late = late || i_rsp_valid !== 1'b1;
		// Missing answer returns all ones, which no check expects
		rsp = late ? '1 : i_rsp;
		#1;
	endtask
endmodule // cmdm_master_model
`default_nettype wire

// file: tb/cmdm_mapper_tb_top.sv
`default_nettype none
module cmdm_mapper_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic init = 1'b0;
	logic comp_en = 1'b0;
	logic [3:0] in_cnt = 4'h0;
	logic [3:0] out_cnt = 4'h0;
	logic [15:0] in_ptr [10];
	logic [15:0] out_ptr [10];
	cmdm_pkg::cmdm_width_e in_w [10];
	cmdm_pkg::cmdm_width_e out_w [10];
	logic [31:0] in_val [10];
	logic awpp_wr = 1'b0;
	logic [7:0] awpp_wd = 8'h00;
	logic req_valid;
	cmdm_pkg::cmdm_req_s req;
	logic req_ready, rsp_valid, out_wr, acyc_valid, running;
	cmdm_pkg::cmdm_rsp_s rsp;
	cmdm_pkg::cmdm_acyc_s acyc;
	logic [3:0] out_chan;
	logic [31:0] out_value;
	logic [15:0] acyc_rdata;
	logic [7:0] in_bytes, out_bytes, awpp, status;
	cmdm_pkg::cmdm_rsp_s r;
	logic [7:0] fcs [5];
	int errors = 0;
	int checked = 0;
	int w0;
	always #20 clk = ~clk;
	cmdm_mapper dut (.i_core_clk(clk), .i_resetn(resetn), .i_init(init),
		.i_cyclic_compression_enable(comp_en), .i_in_channel_count(in_cnt),
		.i_out_channel_count(out_cnt), .i_in_map_pointer(in_ptr), .i_out_map_pointer(out_ptr),
		.i_in_width(in_w), .i_out_width(out_w), .i_in_value(in_val), .i_awpp_wr(awpp_wr),
		.i_awpp_wdata(awpp_wd), .i_req_valid(req_valid), .i_req(req), .o_req_ready(req_ready),
		.o_rsp_valid(rsp_valid), .o_rsp(rsp), .o_out_wr(out_wr), .o_out_chan(out_chan),
		.o_out_value(out_value), .o_acyc_valid(acyc_valid), .o_acyc(acyc),
		.i_acyc_rdata(acyc_rdata), .o_input_cyclic_byte_count(in_bytes),
		.o_output_cyclic_byte_count(out_bytes), .o_acyclic_words_per_parameter(awpp),
		.o_mapping_status(status), .o_running(running));
	cmdm_master_model m (.i_core_clk(clk), .o_req_valid(req_valid), .o_req(req),
		.i_req_ready(req_ready), .i_rsp_valid(rsp_valid), .i_rsp(rsp), .i_acyc_valid(acyc_valid),
		.i_acyc(acyc), .o_acyc_rdata(acyc_rdata), .i_out_wr(out_wr), .i_out_chan(out_chan),
		.i_out_value(out_value));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
			errors++;
		end
	endtask
	task automatic give_verdict();
		if (errors == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Load a mapping; channel zi or zo gets a zero pointer, unused ones stay zero
	task automatic run_init(input logic comp, input logic [3:0] ic, input logic [3:0] oc,
		input logic [3:0] zi, input logic [3:0] zo);
		@(posedge clk);
		comp_en <= comp;
		in_cnt <= ic;
		out_cnt <= oc;
		for (int k = 0; k < 10; k++) begin
			in_ptr[k] <= (k < ic && k != zi) ? 16'h0100 + 16'(k) : 16'h0000;
			out_ptr[k] <= (k < oc && k != zo) ? 16'h0200 + 16'(k) : 16'h0000;
		end
		init <= 1'b1;
		@(posedge clk);
		init <= 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic set_awpp(input logic [7:0] v);
		@(posedge clk);
		awpp_wr <= 1'b1;
		awpp_wd <= v;
		@(posedge clk);
		awpp_wr <= 1'b0;
		@(negedge clk);
	endtask
	initial begin
		for (int k = 0; k < 10; k++) begin
			in_ptr[k] = 16'h0000;
			out_ptr[k] = 16'h0000;
			in_w[k] = (k % 2) ? cmdm_pkg::CMDM_W32 : cmdm_pkg::CMDM_W16;
			out_w[k] = (k % 2) ? cmdm_pkg::CMDM_W1 : cmdm_pkg::CMDM_W32;
			in_val[k] = {16'ha000 + 16'(k), 16'h5000 + 16'(k)};
		end
		fcs = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h17};
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		@(negedge clk);
		chk(32'(in_bytes), 32'h8);
		chk(32'(out_bytes), 32'h8);
		chk(32'(awpp), 32'h1);
		chk(32'(req_ready), 32'h0);
		// Uncompressed, two channels each way
		run_init(1'b0, 4'h2, 4'h2, 4'hf, 4'hf);
		chk(32'(in_bytes), 32'h8);
		chk(32'(out_bytes), 32'h8);
		chk(32'(status), 32'h0);
		chk(32'(running), 32'h1);
		foreach (fcs[i]) begin
			m.do_req(fcs[i], (fcs[i] > 8'h02 && fcs[i] != 8'h04) ? 16'h0100 : 16'h0000, 16'h0, r);
			chk(32'(r.exc), 32'h0);
		end
		m.do_req(8'h04, 16'h0000, 16'h0, r);
		chk(32'(r.data), 32'ha000);
		m.do_req(8'h03, 16'h0103, 16'h0, r);
		chk(32'(r.data), 32'h5001);
		m.do_req(8'h10, 16'h0002, 16'h1234, r);
		chk({28'h0, m.last_chan}, 32'h1);
		chk(m.last_value, 32'h1234_0000);
		m.do_req(8'h06, 16'h0003, 16'h00ab, r);
		chk(m.last_value, 32'h1234_00ab);
		w0 = m.wr_cnt;
		m.do_req(8'h07, 16'h0000, 16'h0, r);
		chk(32'(r.exc), 32'h1);
		m.do_req(8'h03, 16'h0205, 16'h0, r);
		chk(32'(r.exc), 32'h2);
		m.do_req(8'h03, 16'h0004, 16'h0, r);
		chk(32'(r.exc), 32'h2);
		m.do_req(8'h06, 16'h0100, 16'h0001, r);
		chk(32'(r.exc), 32'h2);
		chk(32'(m.wr_cnt - w0), 32'h0);
		// Non-cyclic: two words, then one word per parameter
		m.do_req(8'h03, 16'h0300, 16'h0, r);
		chk(32'(m.last_acyc.param), 32'h79);
		chk(32'(m.last_acyc.hi_word), 32'h1);
		chk(32'(r.data), 32'ha5dc);
		set_awpp(8'h02);
		chk(32'(awpp), 32'h1);
		set_awpp(8'h00);
		chk(32'(awpp), 32'h0);
		m.do_req(8'h10, 16'h0288, 16'h0042, r);
		chk(32'(m.last_acyc.param), 32'h79);
		chk(32'(m.last_acyc.partial), 32'h1);
		chk(32'(m.last_acyc.write), 32'h1);
		chk(32'(m.last_acyc.wdata), 32'h42);
		chk(32'(r.data), 32'h0);
		// Mapping inputs change while running, no initialisation
		@(posedge clk);
		out_cnt <= 4'h5;
		repeat (3) @(negedge clk);
		chk(32'(out_bytes), 32'h8);
		// Compressed: 32-bit plus narrow in each direction
		run_init(1'b1, 4'h2, 4'h2, 4'hf, 4'hf);
		chk(32'(in_bytes), 32'h6);
		chk(32'(out_bytes), 32'h6);
		m.do_req(8'h03, 16'h0102, 16'h0, r);
		chk(32'(r.data), 32'h5001);
		m.do_req(8'h05, 16'h0022, 16'hff00, r);
		chk({28'h0, m.last_chan}, 32'h1);
		chk(m.last_value, 32'h0000_00af);
		m.do_req(8'h0f, 16'h0022, 16'h0000, r);
		chk(m.last_value, 32'h0000_00ab);
		// Invalid configurations
		run_init(1'b0, 4'h3, 4'h2, 4'h2, 4'hf);
		chk(32'(status), 32'h3);
		chk(32'(running), 32'h0);
		chk(32'(req_ready), 32'h0);
		run_init(1'b0, 4'hb, 4'h2, 4'hf, 4'hf);
		chk(32'(status), 32'h1);
		run_init(1'b0, 4'h2, 4'h2, 4'hf, 4'h1);
		chk(32'(status), 32'h4);
		give_verdict();
	end
	initial begin
		#(40 * 6000);
		errors++;
		give_verdict();
	end
endmodule // cmdm_mapper_tb_top
`default_nettype wire
